// File: shared/param_port_pkg.sv
// Shared constants and types for the parameter port block
`default_nettype none

package param_port_pkg;

  // Reference clock period
  localparam int CLK_PERIOD_NS   = 4;

  // Port width and value loaded on reset or address deletion
  localparam int PARAM_WIDTH     = 4;
  localparam logic [PARAM_WIDTH-1:0] PARAM_RESET_VALUE = 4'hF;

  // Pin setup ahead of the strobe edge (designed value, 0.1..0.6 us)
  localparam int SETUP_NS        = 500;
  // Strobe pulse width (5..6 us)
  localparam int STROBE_NS       = 5500;
  // Driver release after the strobe in multiplex mode (0.1..0.6 us)
  localparam int HOLD_NS         = 500;
  // Input acceptance delay after new data (11..13.5 us)
  localparam int ACCEPT_NS       = 12000;

  // Cycle counts; least times round up, all at least one cycle
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCEPT_CYC = (ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Instants counted from the cycle new data reaches the pins
  localparam int T_STROBE_START  = SETUP_CYC;
  localparam int T_STROBE_END    = SETUP_CYC + STROBE_CYC;
  localparam int T_RELEASE       = T_STROBE_END + HOLD_CYC;
  localparam int T_SAMPLE        = ACCEPT_CYC;

  // Sequence timer width and type
  localparam int TICK_WIDTH      = 12;
  typedef logic [TICK_WIDTH-1:0] tick_t;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES     = 2;

  // Output update sequence states
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_ACCEPT
  } seq_state_t;

endpackage

`default_nettype wire

// File: shared/pin_sync_if.sv
// Carrier between the pin synchroniser and the port sequencer
`timescale 1ns/100ps
`default_nettype none

interface pin_sync_if #(parameter int WIDTH = 4);
  logic [WIDTH-1:0] raw;     // Asynchronous pin levels
  logic [WIDTH-1:0] synced;  // Levels on the reference clock

  // Synchroniser side
  modport sync
  (
    input  raw,
    output synced
  );

  // Consumer side
  modport user
  (
    output raw,
    input  synced
  );
endinterface

`default_nettype wire

// File: design/pin_sync.sv
// Two stage synchroniser for the parameter pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync
#(
  parameter int WIDTH = 4
)
(
  input  wire logic    ref_clk,
  input  wire logic    resetn,
  pin_sync_if.sync     pins
);
  import param_port_pkg::*;

  logic [WIDTH-1:0] stage1;       // First stage, read only by stage2
  logic [WIDTH-1:0] stage2;       // Second stage, safe to use
  logic [WIDTH-1:0] next_stage1;  // Next first stage
  logic [WIDTH-1:0] next_stage2;  // Next second stage

  // Refuse a width of nothing
  if (WIDTH < 1)
  begin : g_width_check
    $error("pin_sync width must be at least one");
  end

  // Shift path
  always_comb
  begin
    next_stage1 = pins.raw;
    next_stage2 = stage1;
  end

  // Registers; pins idle high through the open-drain pull-up
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '1;
      stage2 <= '1;
    end
    else
    begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pins.synced = stage2;

endmodule

`default_nettype wire

// File: design/param_port_strobe_io.sv
// Slave-mode parameter port with open-drain pins and parameter strobe
`timescale 1ns/100ps
`default_nettype none

module param_port_strobe_io
#(
  parameter int WIDTH = param_port_pkg::PARAM_WIDTH
)
(
  input  wire logic                                  ref_clk,
  input  wire logic                                  resetn,
  input  wire logic                                  param_write_valid,
  output logic                                       param_write_ready,
  input  wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_write_data,
  input  wire logic                                  delete_address,
  input  wire logic                                  multiplex_param,
  input  wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_pin_in,
  output logic [param_port_pkg::PARAM_WIDTH-1:0]     param_pin_out,
  output logic [param_port_pkg::PARAM_WIDTH-1:0]     param_pin_oe,
  output logic                                       param_strobe_pin_out,
  output logic                                       param_strobe_pin_oe,
  output logic                                       param_reply_valid,
  output logic [param_port_pkg::PARAM_WIDTH-1:0]     param_reply_data,
  output logic [param_port_pkg::PARAM_WIDTH-1:0]     param_out_value,
  output logic                                       data_exchange_inhibit,
  output logic                                       data_port_enable
);
  import param_port_pkg::*;

  // Elaboration checks on width and timing order
  if (WIDTH != PARAM_WIDTH)
  begin : g_width_check
    $error("param_port_strobe_io supports only the documented width");
  end
  if (T_SAMPLE <= T_RELEASE || T_SAMPLE >= (1 << TICK_WIDTH))
  begin : g_timing_check
    $error("param_port_strobe_io timing constants out of order");
  end

  // Sequence state
  seq_state_t               state;          // Current step
  seq_state_t               next_state;     // Next step
  tick_t                    tick;           // Cycles since pins updated
  tick_t                    next_tick;      // Next timer value
  logic                     forced;         // Reset or deletion load
  logic                     next_forced;    // Next forced marker
  logic                     mux_mode;       // Multiplex flag of sequence
  logic                     next_mux_mode;  // Next multiplex marker

  // Port outputs
  logic [WIDTH-1:0]         out_reg;        // Parameter output register
  logic [WIDTH-1:0]         next_out_reg;   // Next register value
  logic [WIDTH-1:0]         pin_oe;         // Pull-down enables
  logic [WIDTH-1:0]         next_pin_oe;    // Next pull-down enables
  logic                     strobe;         // Strobe pulse active
  logic                     next_strobe;    // Next strobe level

  // Reply and data port control
  logic                     reply_valid;    // Reply pulse
  logic                     next_reply_valid;
  logic [WIDTH-1:0]         reply_data;     // Sampled input value
  logic [WIDTH-1:0]         next_reply_data;
  logic                     inhibit;        // Data exchange inhibit
  logic                     next_inhibit;   // Next inhibit value

  // Timer arithmetic
  tick_t                    tick_inc;       // Timer plus one

  // Synchronised pin levels
  pin_sync_if #(.WIDTH(WIDTH)) pins ();

  // Pins are inputs all the time, even while driven low
  assign pins.raw = param_pin_in;

  // Two flops before any logic reads the pins
  pin_sync
  #(
    .WIDTH (WIDTH)
  )
  u_pin_sync
  (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pins    (pins)
  );

  // Timer step, kept at the timer width
  assign tick_inc = tick + tick_t'(1);

  // Next values of the update sequence
  always_comb
  begin
    next_state       = state;
    next_tick        = tick;
    next_forced      = forced;
    next_mux_mode    = mux_mode;
    next_out_reg     = out_reg;
    next_pin_oe      = pin_oe;
    next_strobe      = strobe;
    next_reply_valid = 1'b0;
    next_reply_data  = reply_data;
    next_inhibit     = inhibit;

    if (delete_address)
    begin
      // Deletion aborts any sequence and loads all ones
      next_out_reg  = PARAM_RESET_VALUE;
      next_pin_oe   = '0;
      next_forced   = 1'b1;
      next_mux_mode = multiplex_param;
      next_inhibit  = 1'b1;
      next_strobe   = 1'b0;
      next_tick     = '0;
      // Strobe follows with normal setup timing
      next_state    = ST_SETUP;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // Accept a new parameter value from the master
          if (param_write_valid)
          begin
            // Latch and drive: zero bits pull low, ones release
            next_out_reg  = param_write_data;
            next_pin_oe   = ~param_write_data;
            next_forced   = 1'b0;
            // Multiplex only when the flag reads 1
            next_mux_mode = multiplex_param;
            // Write request clears the inhibit
            next_inhibit  = 1'b0;
            next_tick     = '0;
            next_state    = ST_SETUP;
          end
        end

        ST_SETUP:
        begin
          // Pins settle before the strobe edge
          next_tick = tick_inc;
          if (tick_inc == tick_t'(T_STROBE_START))
          begin
            // Announce the new value
            next_strobe = 1'b1;
            next_state  = ST_STROBE;
          end
        end

        ST_STROBE:
        begin
          // Pulse of fixed width
          next_tick = tick_inc;
          if (tick_inc == tick_t'(T_STROBE_END))
          begin
            next_strobe = 1'b0;
            next_state  = ST_HOLD;
          end
        end

        ST_HOLD:
        begin
          // Hold time after the strobe pulse ends
          next_tick = tick_inc;
          if (tick_inc == tick_t'(T_RELEASE))
          begin
            // Multiplex: drivers off before sampling
            if (mux_mode)
            begin
              next_pin_oe = '0;
            end
            // Reset loads carry no reply
            if (forced)
            begin
              next_state = ST_IDLE;
            end
            else
            begin
              next_state = ST_ACCEPT;
            end
          end
        end

        ST_ACCEPT:
        begin
          // Wait for the acceptance instant
          next_tick = tick_inc;
          if (tick_inc == tick_t'(T_SAMPLE))
          begin
            // Choose wired-AND or external value
            if (mux_mode)
            begin
              next_reply_data = pins.synced;
            end
            else
            begin
              next_reply_data = out_reg & pins.synced;
            end
            // Return the sample to the master
            next_reply_valid = 1'b1;
            next_state       = ST_IDLE;
          end
        end

        default:
        begin
          // Unknown state: return to idle
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequence registers; reset starts a forced load with strobe
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // IC reset loads all ones, drivers off, strobe pending
      state       <= ST_SETUP;
      tick        <= '0;
      forced      <= 1'b1;
      mux_mode    <= 1'b0;
      out_reg     <= PARAM_RESET_VALUE;
      pin_oe      <= '0;
      strobe      <= 1'b0;
      reply_valid <= 1'b0;
      reply_data  <= '0;
      inhibit     <= 1'b1;
    end
    else
    begin
      state       <= next_state;
      tick        <= next_tick;
      forced      <= next_forced;
      mux_mode    <= next_mux_mode;
      out_reg     <= next_out_reg;
      pin_oe      <= next_pin_oe;
      strobe      <= next_strobe;
      reply_valid <= next_reply_valid;
      reply_data  <= next_reply_data;
      inhibit     <= next_inhibit;
    end
  end

  // New writes only while idle and no deletion pending
  assign param_write_ready    = (state == ST_IDLE) && !delete_address;

  // Open-drain pins only ever pull low
  assign param_pin_out        = '0;
  assign param_pin_oe         = pin_oe;

  // Strobe is an active-low open-drain pulse
  assign param_strobe_pin_out = 1'b0;
  assign param_strobe_pin_oe  = strobe;

  // Reply towards the protocol logic
  assign param_reply_valid    = reply_valid;
  assign param_reply_data     = reply_data;

  // Register view and data port control
  assign param_out_value       = out_reg;
  assign data_exchange_inhibit = inhibit;
  assign data_port_enable      = !inhibit;

endmodule

`default_nettype wire

// File: verification/param_port_checker_assertions.sv
// Concurrent checks on the parameter port block's ports
`timescale 1ns/100ps
`default_nettype none

module param_port_checker
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic param_write_valid,
  input wire logic param_write_ready,
  input wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_write_data,
  input wire logic delete_address,
  input wire logic multiplex_param,
  input wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_pin_in,
  input wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_pin_out,
  input wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_pin_oe,
  input wire logic param_strobe_pin_out,
  input wire logic param_strobe_pin_oe,
  input wire logic param_reply_valid,
  input wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_reply_data,
  input wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_out_value,
  input wire logic data_exchange_inhibit,
  input wire logic data_port_enable
);
  import param_port_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic        take;       // Write taken at this edge
  logic [12:0] since;      // Edges since the last take
  logic [12:0] hi;         // Strobe high samples so far
  logic        mux;        // Mode of the running sequence
  logic [12:0] next_since;
  logic [12:0] next_hi;
  logic        next_mux;
  assign take = param_write_valid && param_write_ready;
  // Helper counters, next values
  always_comb
  begin
    next_since = (since == 13'h1FFF) ? since : since + 13'h1;
    next_hi = param_strobe_pin_oe ? hi + 13'h1 : 13'h0;
    next_mux = mux;
    if (take || delete_address)
    begin
      next_since = delete_address ? 13'h1FFF : 13'h0;
      next_mux = multiplex_param;
    end
  end
  // Helper registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      since <= 13'h1FFF;
      hi <= 13'h0;
      mux <= 1'b0;
    end
    else
    begin
      since <= next_since;
      hi <= next_hi;
      mux <= next_mux;
    end
  end
  AST_OPEN_DRAIN: assert property (param_pin_out == '0)
    else $error("pin output level not low");
  AST_STROBE_OD: assert property (param_strobe_pin_out == 1'b0)
    else $error("strobe output level not low");
  AST_LATCH: assert property (take |=> param_out_value ==
    $past(param_write_data) && param_pin_oe == ~$past(param_write_data))
    else $error("written value not on register and pins");
  AST_SETUP: assert property (take |-> ##125 !param_strobe_pin_oe
    ##1 param_strobe_pin_oe) else $error("strobe setup wrong");
  AST_WIDTH: assert property ($fell(param_strobe_pin_oe)
    && !$past(delete_address) |-> hi == STROBE_CYC)
    else $error("strobe width wrong");
  AST_REPLY_TIME: assert property (param_reply_valid
    |-> since == T_SAMPLE) else $error("reply at wrong time");
  AST_REPLY_VALUE: assert property (param_reply_valid |->
    param_reply_data == (mux ? param_pin_in : param_out_value & param_pin_in))
    else $error("reply value wrong");
  AST_RELEASE: assert property ($fell(param_strobe_pin_oe)
    && !$past(delete_address) |-> ##125
    param_pin_oe == (mux ? '0 : ~param_out_value))
    else $error("driver release wrong");
  AST_DELETE: assert property (delete_address |=>
    param_out_value == PARAM_RESET_VALUE && param_pin_oe == '0
    && data_exchange_inhibit) else $error("delete load wrong");
  AST_DEL_STROBE: assert property (delete_address |->
    ##125 !param_strobe_pin_oe ##1 param_strobe_pin_oe)
    else $error("delete strobe missing");
  AST_INHIBIT: assert property (take |=> !data_exchange_inhibit)
    else $error("inhibit not cleared");
  AST_PORT_EN: assert property (data_port_enable != data_exchange_inhibit)
    else $error("data port enable wrong");
  cover property (take && multiplex_param);
  cover property (delete_address);
  cover property (param_reply_valid && mux);
endmodule

bind param_port_strobe_io param_port_checker u_chk (.ref_clk, .resetn,
  .param_write_valid, .param_write_ready, .param_write_data, .delete_address,
  .multiplex_param, .param_pin_in, .param_pin_out, .param_pin_oe,
  .param_strobe_pin_out, .param_strobe_pin_oe, .param_reply_valid,
  .param_reply_data,
  .param_out_value, .data_exchange_inhibit, .data_port_enable);

`default_nettype wire

// File: verification/param_port_partner.sv
// Outside logic on the open-drain parameter pins
`timescale 1ns/100ps
`default_nettype none

module param_port_partner
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic multiplex_param,
  input  wire logic param_strobe_pin_oe,
  input  wire logic [param_port_pkg::PARAM_WIDTH-1:0] param_pin_oe,
  input  wire logic [param_port_pkg::PARAM_WIDTH-1:0] ret_value,
  output logic [param_port_pkg::PARAM_WIDTH-1:0] pin_level,
  output logic [param_port_pkg::PARAM_WIDTH-1:0] read_value
);
  logic drive;      // Return data placed on pins
  logic was_strobe; // Strobe one edge ago
  // Wired line: low if either side pulls, pull-up otherwise
  assign pin_level = ~(param_pin_oe |
    ((drive || !multiplex_param) ? ~ret_value : '0));
  // Read during strobe, drive right after it ends
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive <= 1'b0;
      was_strobe <= 1'b0;
      read_value <= '0;
    end
    else
    begin
      was_strobe <= param_strobe_pin_oe;
      if (param_strobe_pin_oe)
      begin
        drive <= 1'b0;
        read_value <= pin_level;
      end
      else if (was_strobe)
        drive <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// File: verification/param_port_strobe_io_tb.sv
// Self-checking bench for the parameter port block
`timescale 1ns/100ps
`default_nettype none

module param_port_strobe_io_tb;
  import param_port_pkg::*;
  logic ref_clk = 0;
  logic resetn = 0;
  logic param_write_valid = 0;
  logic delete_address = 0;
  logic multiplex_param = 0;
  logic [3:0] param_write_data = 4'h0;
  logic [3:0] ret_value = 4'hF;
  logic [3:0] param_pin_in, param_pin_out, param_pin_oe, read_value;
  logic [3:0] param_reply_data, param_out_value;
  logic param_write_ready, param_strobe_pin_oe, param_reply_valid;
  logic data_exchange_inhibit, data_port_enable;
  int n_mismatch = 0;
  int checked = 0;
  always #2 ref_clk = ~ref_clk;
  param_port_strobe_io DUT (.ref_clk, .resetn, .param_write_valid,
    .param_write_ready, .param_write_data, .delete_address,
    .multiplex_param, .param_pin_in, .param_pin_out, .param_pin_oe,
    .param_strobe_pin_out(), .param_strobe_pin_oe, .param_reply_valid,
    .param_reply_data, .param_out_value, .data_exchange_inhibit,
    .data_port_enable);
  param_port_partner far_end (.ref_clk, .resetn, .multiplex_param,
    .param_strobe_pin_oe, .param_pin_oe, .ret_value,
    .pin_level(param_pin_in), .read_value);
  // Compare and count
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bound ran out
  task automatic guard(int n, int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // Present a write and hold it until taken
  task automatic send(logic [3:0] d, logic m, logic [3:0] r);
    int n;
    @(posedge ref_clk);
    multiplex_param <= m;
    ret_value <= r;
    param_write_data <= d;
    param_write_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (!param_write_ready && n < 4000);
    guard(n, 4000);
    param_write_valid <= 1'b0;
  endtask
  // Reset, forced strobe, default outputs
  task automatic reset_run;
    int n;
    int hi;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    check("out", param_out_value, PARAM_RESET_VALUE);
    check("oe", param_pin_oe, 4'h0);
    check("port", data_port_enable, 1'b0);
    n = 0;
    hi = 0;
    while (!param_write_ready && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
      hi += param_strobe_pin_oe;
    end
    guard(n, 4000);
    check("rst strobe", 16'(hi), 16'(STROBE_CYC));
  endtask
  // One full write with its reply
  task automatic write_param(logic [3:0] d, logic m, logic [3:0] r,
                             logic [3:0] e);
    int n;
    send(d, m, r);
    @(posedge ref_clk);
    n = 1;
    check("value", param_out_value, d);
    check("inhibit", data_exchange_inhibit, 1'b0);
    check("port", data_port_enable, 1'b1);
    while (!param_strobe_pin_oe && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    // Reads just after an edge show the previous edge's update
    check("setup", 16'(n - 1), 16'(T_STROBE_START));
    check("pins", param_pin_oe, 4'(~d));
    while (!param_reply_valid && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
    end
    guard(n, 4000);
    check("delay", 16'(n - 1), 16'(T_SAMPLE));
    check("reply", param_reply_data, e);
    if (m)
      check("read", read_value, d);
  endtask
  // Delete in mid-sequence: abort, load ones, strobe, no reply
  task automatic delete_mid;
    int n;
    int hi;
    int rep;
    send(4'h0, 1'b0, 4'hF);
    repeat (200) @(posedge ref_clk);
    delete_address <= 1'b1;
    @(posedge ref_clk);
    delete_address <= 1'b0;
    @(posedge ref_clk);
    check("del out", param_out_value, PARAM_RESET_VALUE);
    check("del oe", param_pin_oe, 4'h0);
    check("del port", data_port_enable, 1'b0);
    n = 0;
    hi = 0;
    rep = 0;
    while (!param_write_ready && n < 4000)
    begin
      @(posedge ref_clk);
      n++;
      hi += param_strobe_pin_oe;
      rep += param_reply_valid;
    end
    guard(n, 4000);
    check("del strobe", 16'(hi), 16'(STROBE_CYC));
    check("del reply", 16'(rep), 16'h0000);
  endtask
  // Main sequence
  initial
  begin
    reset_run();
    write_param(4'hA, 1'b0, 4'h6, 4'h2);
    write_param(4'h5, 1'b1, 4'hC, 4'hC);
    write_param(4'hF, 1'b1, 4'h3, 4'h3);
    write_param(4'h0, 1'b0, 4'hF, 4'h0);
    delete_mid();
    write_param(4'h9, 1'b0, 4'hF, 4'h9);
    stop_test();
  end
endmodule

`default_nettype wire
